// ### inc/ief_defines.svh
// offsets, field positions, reset values and timing counts of the event chain
`ifndef IEF_DEFINES_SVH
`define IEF_DEFINES_SVH
`define IEF_NUM_CH 10
`define IEF_FILT_CH 200
`define IEF_FIFO_DEPTH 16
`define IEF_FIFO_AW 4
`define IEF_CLK_NS 100
`define IEF_MS_NS 1000000
`define IEF_MS_CYCLES (`IEF_MS_NS / `IEF_CLK_NS)
`define IEF_CHAT_UNIT_MS 100
`define IEF_REG_STATUS 12'h000
`define IEF_REG_CYCLE 12'h004
`define IEF_REG_OFFER 12'h008
`define IEF_REG_OFFER_TSL 12'h00C
`define IEF_REG_OFFER_TSH 12'h010
`define IEF_REG_TIME_LO 12'h014
`define IEF_REG_TIME_HI 12'h018
`define IEF_CH_PAGE 4'h1
`define IEF_CH_CTRL 4'h0
`define IEF_CH_CHAT 4'h4
`define IEF_CH_LIMIT 4'h8
`define IEF_CH_STATE 4'hC
`define IEF_CTRL_INV 0
`define IEF_CTRL_DEB_LSB 16
`define IEF_CTRL_DEB_MSB 30
`define IEF_CHAT_WIN_LSB 0
`define IEF_CHAT_WIN_MSB 15
`define IEF_CHAT_BLK_LSB 16
`define IEF_CHAT_BLK_MSB 31
`define IEF_RST_DEB 15'h0000
`define IEF_RST_WIN 16'h0000
`define IEF_RST_BLK 16'h0001
`define IEF_RST_LIMIT 8'h01
`endif

// ### inc/ief_pkg.sv
// types shared by the input event filter chain
package ief_pkg;
   typedef logic [3:0] ief_ch_t;
   // one stored event record
   typedef struct packed {
      ief_ch_t ch;
      logic value;
      logic blocked;
      logic ovf;
      logic [63:0] ts;
   } ief_entry_t;
   // per-channel filter settings
   typedef struct packed {
      logic inv;
      logic [14:0] deb;
      logic [15:0] win;
      logic [15:0] blk;
      logic [7:0] lim;
   } ief_cfg_t;
endpackage

// ### src/ief_top.sv
// input event filter chain: inversion, debounce, chatter, event fifo, apb
`timescale 1ns/1ns
`include "ief_defines.svh"
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module ief_top #(
   parameter int MS_CYCLES = `IEF_MS_CYCLES
) (
   input wire logic I_CLK,
   input wire logic I_RESETN,
   input wire logic [`IEF_NUM_CH-1:0] I_DIN,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [11:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   output logic O_OFFER_VALID
);
   localparam int N = `IEF_NUM_CH;
   localparam int DEPTH = `IEF_FIFO_DEPTH;
   localparam int AW = `IEF_FIFO_AW;

   logic [13:0] ms_div_q;
   logic [6:0] unit_q;
   logic tick_ms_q, tick_u_q;
   logic [63:0] ts_q;
   logic [N-1:0] sync1_q, sync2_q, x;
   ief_pkg::ief_cfg_t cfg_q [N];
   logic [N-1:0] stable_q, run_q, deb_ev_q;
   logic [14:0] tmr_q [N];
   logic [63:0] cap_q [N];
   logic [63:0] deb_ts_q [N];
   logic [N-1:0] blocked_q, chat_ev_q;
   logic [15:0] age_q [N];
   logic [15:0] blk_q [N];
   logic [7:0] cnt_q [N];
   ief_pkg::ief_entry_t chat_q [N];
   ief_pkg::ief_entry_t slot_q [N];
   logic [N-1:0] slot_v_q, gnt, lost;
   logic gnt_v;
   ief_pkg::ief_ch_t gnt_idx;
   ief_pkg::ief_entry_t mem [DEPTH];
   logic [AW-1:0] wp_q, rp_q;
   logic [AW:0] cnt_f_q;
   logic full, empty, push, pop, ovf_pend_q;
   ief_pkg::ief_entry_t offer_q;
   logic setup, wr, cyc_wr, ch_hit, map_ok;
   logic [3:0] ch_sel;
   logic [31:0] rdata;

   //////////////////////////////////////////////////////////////////////////
   // time base: 1 ms enable and 100 ms enable from the module clock
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         ms_div_q <= 14'h0000;
         tick_ms_q <= 1'b0;
      end else begin
         tick_ms_q <= (ms_div_q == 14'(MS_CYCLES - 1));
         if (ms_div_q == 14'(MS_CYCLES - 1)) begin
            ms_div_q <= 14'h0000;
         end else begin
            ms_div_q <= ms_div_q + 14'h0001;
         end
      end
   end

   // chatter unit counts whole milliseconds, stamp counter shares the tick
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         unit_q <= 7'h00;
         tick_u_q <= 1'b0;
         ts_q <= 64'h0000000000000000;
      end else begin
         tick_u_q <= 1'b0;
         if (tick_ms_q) begin
            ts_q <= ts_q + 64'h0000000000000001;
            if (unit_q == 7'(`IEF_CHAT_UNIT_MS - 1)) begin
               unit_q <= 7'h00;
               tick_u_q <= 1'b1;
            end else begin
               unit_q <= unit_q + 7'h01;
            end
         end
      end
   end

   // pins are asynchronous to the clock: two stages before any use
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= I_DIN;
         sync2_q <= sync1_q;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // apb decode; answer is registered, so every access has one access cycle
   assign setup = I_PSEL && !I_PENABLE;
   assign wr = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY;
   assign cyc_wr = wr && (I_PADDR == `IEF_REG_CYCLE);
   assign ch_sel = I_PADDR[7:4];
   assign ch_hit = (I_PADDR[11:8] == `IEF_CH_PAGE) && (ch_sel < 4'(N));

   // read mux and map check
   always_comb begin
      rdata = 32'h00000000;
      map_ok = 1'b1;
      case (I_PADDR)
         `IEF_REG_STATUS: rdata = {23'h000000, ovf_pend_q, 3'h0, cnt_f_q};
         `IEF_REG_CYCLE: rdata = 32'h00000000;
         `IEF_REG_OFFER: rdata = {20'h00000, offer_q.ch, 4'h0, offer_q.ovf,
                                  offer_q.blocked, offer_q.value,
                                  O_OFFER_VALID};
         `IEF_REG_OFFER_TSL: rdata = offer_q.ts[31:0];
         `IEF_REG_OFFER_TSH: rdata = offer_q.ts[63:32];
         `IEF_REG_TIME_LO: rdata = ts_q[31:0];
         `IEF_REG_TIME_HI: rdata = ts_q[63:32];
         default: begin
            map_ok = ch_hit && (I_PADDR[1:0] == 2'h0);
            if (map_ok) begin
               case (I_PADDR[3:0])
                  `IEF_CH_CTRL: rdata = {1'b0, cfg_q[ch_sel].deb, 15'h0000,
                                         cfg_q[ch_sel].inv};
                  `IEF_CH_CHAT: rdata = {cfg_q[ch_sel].blk,
                                         cfg_q[ch_sel].win};
                  `IEF_CH_LIMIT: rdata = {24'h000000, cfg_q[ch_sel].lim};
                  `IEF_CH_STATE: rdata = {16'h0000, cnt_q[ch_sel], 6'h00,
                                          blocked_q[ch_sel],
                                          stable_q[ch_sel]};
                  default: map_ok = 1'b0;
               endcase
            end
         end
      endcase
   end

   // answer registered in the setup cycle, ready in the first access cycle
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         O_PREADY <= 1'b0;
         O_PRDATA <= 32'h00000000;
         O_PSLVERR <= 1'b0;
      end else begin
         O_PREADY <= setup;
         O_PRDATA <= (setup && !I_PWRITE) ? rdata : 32'h00000000;
         O_PSLVERR <= setup && !map_ok;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // per-channel configuration, inversion, debounce, chatter and slot
   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_ch
         localparam logic [3:0] CH = 4'(gi);
         logic hit;
         assign hit = wr && ch_hit && (ch_sel == CH);
         assign x[gi] = sync2_q[gi] ^ cfg_q[gi].inv;

         // configuration, separate for every input
         always_ff @(posedge I_CLK) begin
            if (!I_RESETN) begin
               cfg_q[gi] <= '{inv: 1'b0, deb: `IEF_RST_DEB,
                              win: `IEF_RST_WIN, blk: `IEF_RST_BLK,
                              lim: `IEF_RST_LIMIT};
            end else if (hit) begin
               case (I_PADDR[3:0])
                  `IEF_CH_CTRL: begin
                     cfg_q[gi].inv <= I_PWDATA[`IEF_CTRL_INV];
                     cfg_q[gi].deb <= I_PWDATA[`IEF_CTRL_DEB_MSB:
                                               `IEF_CTRL_DEB_LSB];
                  end
                  `IEF_CH_CHAT: begin
                     cfg_q[gi].win <= I_PWDATA[`IEF_CHAT_WIN_MSB:
                                               `IEF_CHAT_WIN_LSB];
                     cfg_q[gi].blk <= I_PWDATA[`IEF_CHAT_BLK_MSB:
                                               `IEF_CHAT_BLK_LSB];
                  end
                  `IEF_CH_LIMIT: cfg_q[gi].lim <= I_PWDATA[7:0];
                  default: cfg_q[gi].lim <= cfg_q[gi].lim;
               endcase
            end
         end

         // debounce: zero time, or a channel past the limit, passes at once
         always_ff @(posedge I_CLK) begin
            if (!I_RESETN) begin
               stable_q[gi] <= 1'b0;
               run_q[gi] <= 1'b0;
               deb_ev_q[gi] <= 1'b0;
               tmr_q[gi] <= 15'h0000;
               cap_q[gi] <= 64'h0000000000000000;
               deb_ts_q[gi] <= 64'h0000000000000000;
            end else begin
               deb_ev_q[gi] <= 1'b0;
               if (run_q[gi]) begin
                  if (x[gi] == stable_q[gi]) begin
                     run_q[gi] <= 1'b0;
                  end else if (tick_ms_q) begin
                     if (tmr_q[gi] == 15'h0001) begin
                        run_q[gi] <= 1'b0;
                        stable_q[gi] <= x[gi];
                        deb_ev_q[gi] <= 1'b1;
                        deb_ts_q[gi] <= cap_q[gi];
                     end else begin
                        tmr_q[gi] <= tmr_q[gi] - 15'h0001;
                     end
                  end
               end else if (x[gi] != stable_q[gi]) begin
                  if (cfg_q[gi].deb == 15'h0000 || gi >= `IEF_FILT_CH) begin
                     stable_q[gi] <= x[gi];
                     deb_ev_q[gi] <= 1'b1;
                     deb_ts_q[gi] <= ts_q;
                  end else begin
                     run_q[gi] <= 1'b1;
                     tmr_q[gi] <= cfg_q[gi].deb;
                     cap_q[gi] <= ts_q;
                  end
               end
            end
         end

         // chatter: counts short states, blocks, reports both switches
         always_ff @(posedge I_CLK) begin
            if (!I_RESETN) begin
               blocked_q[gi] <= 1'b0;
               chat_ev_q[gi] <= 1'b0;
               age_q[gi] <= 16'h0000;
               blk_q[gi] <= 16'h0000;
               cnt_q[gi] <= 8'h00;
               chat_q[gi] <= '0;
            end else begin
               chat_ev_q[gi] <= 1'b0;
               chat_q[gi].ch <= CH;
               chat_q[gi].value <= stable_q[gi];
               chat_q[gi].ovf <= 1'b0;
               if (cfg_q[gi].win == 16'h0000 || gi >= `IEF_FILT_CH) begin
                  blocked_q[gi] <= 1'b0;
                  cnt_q[gi] <= 8'h00;
                  // keep ageing so a later enable judges the real state age
                  if (deb_ev_q[gi]) begin
                     age_q[gi] <= 16'h0000;
                  end else if (tick_u_q && age_q[gi] != 16'hFFFF) begin
                     age_q[gi] <= age_q[gi] + 16'h0001;
                  end
                  chat_ev_q[gi] <= deb_ev_q[gi];
                  chat_q[gi].blocked <= 1'b0;
                  chat_q[gi].ts <= deb_ts_q[gi];
               end else if (blocked_q[gi]) begin
                  if (tick_u_q) begin
                     if (blk_q[gi] <= 16'h0001) begin
                        blocked_q[gi] <= 1'b0;
                        cnt_q[gi] <= 8'h00;
                        age_q[gi] <= 16'h0000;
                        chat_ev_q[gi] <= 1'b1;
                        chat_q[gi].blocked <= 1'b0;
                        chat_q[gi].ts <= ts_q;
                     end else begin
                        blk_q[gi] <= blk_q[gi] - 16'h0001;
                     end
                  end
               end else if (deb_ev_q[gi]) begin
                  age_q[gi] <= 16'h0000;
                  chat_ev_q[gi] <= 1'b1;
                  chat_q[gi].blocked <= 1'b0;
                  chat_q[gi].ts <= deb_ts_q[gi];
                  if (age_q[gi] < cfg_q[gi].win) begin
                     if (cnt_q[gi] >= cfg_q[gi].lim) begin
                        blocked_q[gi] <= 1'b1;
                        blk_q[gi] <= cfg_q[gi].blk;
                        chat_q[gi].blocked <= 1'b1;
                        chat_q[gi].ts <= ts_q;
                     end else begin
                        cnt_q[gi] <= cnt_q[gi] + 8'h01;
                     end
                  end
               end else if (tick_u_q) begin
                  if (age_q[gi] != 16'hFFFF) begin
                     age_q[gi] <= age_q[gi] + 16'h0001;
                  end
                  if (age_q[gi] + 16'h0001 >= cfg_q[gi].win) begin
                     cnt_q[gi] <= 8'h00;
                  end
               end
            end
         end

         // one pending slot per channel; a new event always wins the slot
         assign lost[gi] = chat_ev_q[gi] && slot_v_q[gi] && !gnt[gi];
         always_ff @(posedge I_CLK) begin
            if (!I_RESETN) begin
               slot_v_q[gi] <= 1'b0;
               slot_q[gi] <= '0;
            end else if (chat_ev_q[gi]) begin
               slot_v_q[gi] <= 1'b1;
               slot_q[gi] <= chat_q[gi];
            end else if (gnt[gi]) begin
               slot_v_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////////
   // lowest pending channel goes to the fifo first
   always_comb begin
      gnt = '0;
      gnt_v = 1'b0;
      gnt_idx = 4'h0;
      for (int k = N - 1; k >= 0; k--) begin
         if (slot_v_q[k]) begin
            gnt_idx = 4'(k);
            gnt_v = 1'b1;
         end
      end
      if (gnt_v) begin
         gnt[gnt_idx] = 1'b1;
      end
   end

   assign full = (cnt_f_q == (AW + 1)'(DEPTH));
   assign empty = (cnt_f_q == '0);
   assign push = gnt_v && !full;
   assign pop = cyc_wr && !empty;

   // fifo storage; a full fifo drops the event instead of stalling inputs
   always_ff @(posedge I_CLK) begin
      if (push) begin
         mem[wp_q] <= '{ch: slot_q[gnt_idx].ch,
                        value: slot_q[gnt_idx].value,
                        blocked: slot_q[gnt_idx].blocked,
                        ovf: ovf_pend_q, ts: slot_q[gnt_idx].ts};
      end
   end

   // pointers and fill count
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_f_q <= '0;
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
         cnt_f_q <= cnt_f_q + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end

   // overflow marker: a new loss wins over the clear by a stored entry
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         ovf_pend_q <= 1'b0;
      end else if ((gnt_v && full) || (|lost)) begin
         ovf_pend_q <= 1'b1;
      end else if (push) begin
         ovf_pend_q <= 1'b0;
      end
   end

   // each cycle strobe replaces the offer; an unread one is gone for good
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         O_OFFER_VALID <= 1'b0;
         offer_q <= '0;
      end else if (cyc_wr) begin
         O_OFFER_VALID <= !empty;
         offer_q <= empty ? '0 : mem[rp_q];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // checks on every channel and the fifo; a single watched channel would
   // leave the filter checks idle whenever other inputs carry the traffic
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RESETN);

   genvar ci;
   generate
      for (ci = 0; ci < N; ci++) begin : g_chk
         sequence s_blk_start;
            !blocked_q[ci] && deb_ev_q[ci] && cfg_q[ci].win != 16'h0000 &&
            age_q[ci] < cfg_q[ci].win && cnt_q[ci] >= cfg_q[ci].lim;
         endsequence
         sequence s_blk_end;
            blocked_q[ci] && tick_u_q && blk_q[ci] <= 16'h0001 &&
            cfg_q[ci].win != 16'h0000;
         endsequence

         a_deb_start: assert property (!run_q[ci] &&
            x[ci] != stable_q[ci] && cfg_q[ci].deb != 15'h0000 |=>
            run_q[ci] && !deb_ev_q[ci] && tmr_q[ci] == $past(cfg_q[ci].deb))
            else $error("debounce timer not started");
         a_deb_cancel: assert property (run_q[ci] &&
            x[ci] == stable_q[ci] |=> !run_q[ci] && !deb_ev_q[ci])
            else $error("debounce not cancelled");
         a_deb_zero: assert property (!run_q[ci] &&
            x[ci] != stable_q[ci] && cfg_q[ci].deb == 15'h0000 |=>
            deb_ev_q[ci] && deb_ts_q[ci] == $past(ts_q)
            ##1 (chat_ev_q[ci] || blocked_q[ci]))
            else $error("zero debounce did not pass");
         a_deb_stamp: assert property (run_q[ci] &&
            x[ci] != stable_q[ci] && tick_ms_q && tmr_q[ci] == 15'h0001
            |=> deb_ev_q[ci] && deb_ts_q[ci] == $past(cap_q[ci]) &&
            stable_q[ci] == $past(x[ci]))
            else $error("debounce expiry stamp wrong");
         a_chat_discard: assert property (blocked_q[ci] &&
            !tick_u_q && cfg_q[ci].win != 16'h0000 |=> !chat_ev_q[ci])
            else $error("blocked channel passed a change");
         a_chat_enter: assert property (s_blk_start |=>
            blocked_q[ci] && chat_ev_q[ci] && chat_q[ci].blocked &&
            blk_q[ci] == $past(cfg_q[ci].blk))
            else $error("chatter block not entered");
         a_chat_leave: assert property (s_blk_end |=>
            !blocked_q[ci] && cnt_q[ci] == 8'h00 && chat_ev_q[ci] &&
            !chat_q[ci].blocked)
            else $error("chatter block not left");
      end
   endgenerate
   a_fifo_ovf: assert property (gnt_v && full && !pop |=> ovf_pend_q &&
      cnt_f_q == (AW + 1)'(DEPTH))
      else $error("overflow not flagged");
   a_offer_once: assert property (cyc_wr && !empty |=> O_OFFER_VALID &&
      offer_q == $past(mem[rp_q]) && cnt_f_q == $past(cnt_f_q) -
      (AW + 1)'(1) + (AW + 1)'($past(push)))
      else $error("offer not taken from fifo");
   a_ts_tick: assert property (tick_ms_q |=> ts_q == $past(ts_q) +
      64'h0000000000000001)
      else $error("timestamp not advanced");
endmodule

// ### verification/ief_field_model.sv
// field input model: contacts and sensors wired to the filter chain
`timescale 1ns/1ns
`include "ief_defines.svh"
module ief_field_model (
   input wire logic i_clk,
   output logic [`IEF_NUM_CH-1:0] o_din
);
   // contacts start open so no level is seen high at reset release
   initial o_din = '0;
   // levels move just after an edge so the sync flops never see a race
   task automatic put(input logic [`IEF_NUM_CH-1:0] v);
      @(posedge i_clk);
      o_din <= v;
   endtask
endmodule

// ### verification/ief_top_tb.sv
// self-checking bench for the input event filter chain
`timescale 1ns/1ns
`include "ief_defines.svh"
module ief_top_tb;
   localparam int MSC = 10;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, r, t0;
   logic pready, pslverr, offer_valid, err;
   logic [`IEF_NUM_CH-1:0] din;
   logic [`IEF_NUM_CH-1:0] cur = '0;
   int num_errors = 0;
   int checked = 0;

   // 10 MHz module clock
   always #50 clk = ~clk;

   ief_field_model fld (.i_clk(clk), .o_din(din));

   // short millisecond so the chatter ticks fit in the run
   ief_top #(.MS_CYCLES(MSC)) dut (
      .I_CLK(clk), .I_RESETN(rst_n), .I_DIN(din), .I_PSEL(psel),
      .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
      .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .O_OFFER_VALID(offer_valid)
   );

   //////////////////////////////////////////////////////////////////////////
   // bus, compare and timing helpers
   function automatic logic [11:0] chr(input logic [3:0] c, logic [3:0] o);
      return {`IEF_CH_PAGE, c, o};
   endfunction

   task automatic chk(input string what, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, seen);
         num_errors++;
      end
   endtask

   // request held until pready is sampled high, then released
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees pready
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic ms(input int n);
      repeat (n * MSC) @(posedge clk);
   endtask

   // start an application cycle and judge what is offered
   task automatic pop(input logic [31:0] e);
      apb(1'b1, `IEF_REG_CYCLE, 32'h00000000);
      apb(1'b0, `IEF_REG_OFFER, 32'h00000000);
      chk("offer", r, e);
      chk("offer_valid", {31'h0, offer_valid}, {31'h0, e[0]});
   endtask

   task automatic give_verdict;
      if (num_errors == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   //////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset;
      chk("valid_rst", {31'h0, offer_valid}, 32'h00000000);
      apb(1'b0, chr(4'h0, `IEF_CH_CTRL), 32'h0);
      chk("ctrl_rst", r, 32'h00000000);
      apb(1'b0, chr(4'h9, `IEF_CH_CHAT), 32'h0);
      chk("chat_rst", r, 32'h00010000);
      apb(1'b0, chr(4'h5, `IEF_CH_LIMIT), 32'h0);
      chk("limit_rst", r, 32'h00000001);
      // unmapped place answers with an error and no data
      apb(1'b0, 12'hFFC, 32'h0);
      chk("unmapped_err", {31'h0, err}, 32'h00000001);
      chk("unmapped_data", r, 32'h00000000);
   endtask

   // inverted idle input and an undebounced edge, then an empty cycle
   task automatic t_first;
      apb(1'b1, chr(4'h4, `IEF_CH_CTRL), 32'h00000001);
      ms(1);
      cur[0] = 1'b1;
      fld.put(cur);
      ms(1);
      pop(32'h00000403);
      pop(32'h00000003);
      pop(32'h00000000);
   endtask

   task automatic t_debounce;
      apb(1'b1, chr(4'h2, `IEF_CH_CTRL), 32'h00050000);
      cur[2] = 1'b1;
      fld.put(cur);
      ms(2);
      cur[2] = 1'b0;
      fld.put(cur);
      ms(8);
      apb(1'b0, `IEF_REG_STATUS, 32'h0);
      chk("excursion", r, 32'h00000000);
      apb(1'b0, `IEF_REG_TIME_LO, 32'h0);
      t0 = r;
      cur[2] = 1'b1;
      fld.put(cur);
      ms(3);
      apb(1'b0, `IEF_REG_STATUS, 32'h0);
      chk("held_back", r, 32'h00000000);
      ms(4);
      pop(32'h00000203);
      apb(1'b0, `IEF_REG_OFFER_TSL, 32'h0);
      chk("stamp", {31'h0, (r - t0) <= 32'h1}, 32'h00000001);
   endtask

   // long idle first so the opening edge is not a short state
   task automatic t_chatter;
      ms(400);
      apb(1'b1, chr(4'h3, `IEF_CH_CHAT), 32'h00010003);
      cur[3] = 1'b1;
      fld.put(cur);
      ms(5);
      cur[3] = 1'b0;
      fld.put(cur);
      ms(5);
      cur[3] = 1'b1;
      fld.put(cur);
      ms(250);
      apb(1'b0, `IEF_REG_STATUS, 32'h0);
      chk("chatter_count", r, 32'h00000004);
      pop(32'h00000303);
      pop(32'h00000301);
      pop(32'h00000307);
      pop(32'h00000303);
   endtask

   // twenty events into sixteen places, then the flag rides the next one
   task automatic t_overflow;
      apb(1'b1, chr(4'h3, `IEF_CH_CHAT), 32'h00010000);
      cur = ~cur;
      fld.put(cur);
      ms(10);
      cur = ~cur;
      fld.put(cur);
      ms(10);
      apb(1'b0, `IEF_REG_STATUS, 32'h0);
      chk("full", r, 32'h00000110);
      repeat (16) apb(1'b1, `IEF_REG_CYCLE, 32'h0);
      cur[0] = ~cur[0];
      fld.put(cur);
      ms(1);
      pop(32'h00000009);
   endtask

   // main sequence after six reset cycles
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_first;
      t_debounce;
      t_chatter;
      t_overflow;
      give_verdict;
   end

   // run needs about 0.72 ms of simulated time, well inside the 3 ms watchdog
   initial begin
      #3000000;
      num_errors++;
      give_verdict;
   end
endmodule
